// ---- svrh_core.sv ----
/*
 Status and command core of a fieldbus servo drive: speed-reached detection,
 operation enable, pause, mode selection and the homing sequencer with its
 origin offset. Assumes the motion feedback inputs come from logic on
 sys_clk_i, the home switch is an asynchronous pin, and object accesses are
 single-cycle strobes from the process-data engine.
*/
// How it works
// (RQ1) Speed reached once rpm error stays inside threshold for window milliseconds.
// (RQ2) Speed reached only while enabled in profile or cyclic velocity mode.
// (RQ3) Speed-reached output moves together with status bit ten; in the code only in velocity modes, else bit ten shows position reached.
// (RQ4) Writes selecting torque mode are refused; the active mode stays.
// (RQ5) Finished homing makes the stop point equal zero plus signed offset.
// (RQ6) Drive operates only when control word bits zero to three are set.
// (RQ7) Rising edge of control bit four starts homing in homing mode.
// (RQ8) Falling edge of control bit four ends the homing operation.
// (RQ9) Control bit eight pauses motion using the selected pause option.
// (RQ10) Status bit twelve reports success once target reached in homing mode.
// (RQ11) Status bit thirteen flags homing timeout or excessive deviation.
// (RQ12) Status bit fifteen sets when the home signal is met.
// (RQ13) Position reach threshold and millisecond window judge target arrival.
// (RQ14) Homing method is signed 8-bit, legal one to thirty-five, reset one.
// (RQ15) Fast and slow search speeds default to 100; slow minimum ten.
// (RQ16) Rest position after homing becomes the feedback origin reference.
// (RQ17) Controller maps control word, target velocity and status word.
// (RQ18) Calculation object zero loads offset, one adds offset to feedback.
// (RQ19) Starting homing clears success, error and home-found bits.
`timescale 1ns/10ps
module svrh_core
  import svrh_pkg::*;
#(
  parameter int CYC_PER_MS_P = CYC_PER_MS,
  parameter logic [15:0] VEL_GAIN = 16'h0001,
  parameter int VEL_SHIFT = 0,
  parameter logic [31:0] HOME_TIMEOUT_MS = 32'h00002710,
  parameter logic [31:0] HOME_DEV_LIMIT = 32'h00100000
) (
  // Clock and reset.
  input wire logic sys_clk_i,
  input wire logic rst_i,
  // Object access from the process-data engine.
  input wire logic obj_wr_i,
  input wire logic obj_rd_i,
  input wire logic [15:0] obj_index_i,
  input wire logic [7:0] obj_sub_i,
  input wire logic [31:0] obj_wdata_i,
  output logic [31:0] obj_rdata_o,
  output logic obj_ack_o,
  output logic obj_err_o,
  // Motion feedback on the system clock.
  input wire logic [31:0] motor_rpm_i,
  input wire logic [31:0] raw_position_i,
  input wire logic [31:0] pos_demand_i,
  input wire logic [31:0] speed_feedback_i,
  input wire logic [15:0] torque_i,
  input wire logic [31:0] follow_err_i,
  input wire logic homing_stop_i,
  // Home switch pin.
  input wire logic home_sw_i,
  // Drive control outputs.
  output logic drive_enable_o,
  output logic [7:0] active_mode_o,
  output logic pause_o,
  output logic [15:0] pause_option_o,
  output logic speed_reached_do_o,
  output logic [15:0] status_word_o,
  output logic [31:0] position_feedback_o,
  // Homing trajectory settings.
  output logic homing_run_o,
  output logic [7:0] homing_method_o,
  output logic [31:0] homing_fast_o,
  output logic [31:0] homing_slow_o,
  output logic [31:0] homing_accel_o
);
  // Object registers.
  logic [15:0] cw_q, cw_d, err_code_q, err_code_d, pause_opt_q, pause_opt_d;
  logic [7:0] mode_q, mode_d, method_q, method_d;
  logic [31:0] pos_thr_q, pos_thr_d, origin_q, origin_d, tgt_vel_q, tgt_vel_d;
  logic [15:0] pos_win_q, pos_win_d, spd_thr_q, spd_thr_d, spd_win_q, spd_win_d;
  logic [31:0] fast_q, fast_d, slow_q, slow_d, accel_q, accel_d;
  logic calc_q, calc_d;
  logic [31:0] rdata_q, rdata_d;
  logic ack_q, ack_d, err_q, err_d;
  // Detector and homing state.
  logic [31:0] ms_cnt_q, ms_cnt_d;
  logic tick_q, tick_d;
  logic [15:0] spd_cnt_q, spd_cnt_d, pos_cnt_q, pos_cnt_d;
  logic spd_ok_q, spd_ok_d, pos_ok_q, pos_ok_d;
  svrh_home_t home_q, home_d;
  logic [31:0] to_cnt_q, to_cnt_d, ofs_q, ofs_d, pfb_q, pfb_d;
  logic found_q, found_d, hok_q, hok_d, herr_q, herr_d;
  logic bit4_prev_q, en_q, en_d, pause_q, pause_d;
  logic [15:0] sw_q, sw_d;
  logic home_meta_q, home_sync_q, home_prev_q;
  // Combinational helpers.
  logic enable_ok, vel_mode, home_start, home_rise, spd_in_band, pos_in_band, dev_big;
  logic signed [48:0] vel_prod;
  logic signed [48:0] vel_shift;
  logic [32:0] spd_diff, spd_abs, fe_abs;

  // Speed command converted to motor rpm by a fixed-point gain; the product is
  // kept at full width so large command speeds do not wrap before the shift.
  always_comb begin
    vel_prod = $signed(tgt_vel_q) * $signed({1'b0, VEL_GAIN});
    vel_shift = vel_prod >>> VEL_SHIFT;
    spd_diff = {vel_shift[31], vel_shift[31:0]} - {motor_rpm_i[31], motor_rpm_i};
    spd_abs = spd_diff[32] ? (33'h0 - spd_diff) : spd_diff;
    fe_abs = follow_err_i[31] ? (33'h0 - {1'b1, follow_err_i}) : {1'b0, follow_err_i};
    // (RQ1) Speed error band.
    spd_in_band = spd_abs <= {17'h0, spd_thr_q};
    // (RQ13) Position error band.
    pos_in_band = fe_abs <= {1'b0, pos_thr_q};
    dev_big = fe_abs > {1'b0, HOME_DEV_LIMIT};
    // (RQ6) All four start bits.
    enable_ok = &cw_q[3:0];
    vel_mode = (mode_q == MODE_PV) || (mode_q == MODE_CSV);
    // (RQ7) Homing start edge.
    home_start = (mode_q == MODE_HM) && enable_ok && cw_q[CW_HOMING_BIT] && !bit4_prev_q;
    home_rise = home_sync_q && !home_prev_q;
  end

  // Object write and read decode; unmapped or read-only targets answer with an error.
  always_comb begin
    cw_d = cw_q;
    pause_opt_d = pause_opt_q;
    mode_d = mode_q;
    pos_thr_d = pos_thr_q;
    pos_win_d = pos_win_q;
    spd_thr_d = spd_thr_q;
    spd_win_d = spd_win_q;
    origin_d = origin_q;
    method_d = method_q;
    fast_d = fast_q;
    slow_d = slow_q;
    accel_d = accel_q;
    calc_d = calc_q;
    tgt_vel_d = tgt_vel_q;
    rdata_d = rdata_q;
    ack_d = obj_wr_i || obj_rd_i;
    err_d = 1'b0;
    if (obj_wr_i) begin
      unique case (obj_index_i)
        IDX_CONTROL: cw_d = obj_wdata_i[15:0];
        IDX_PAUSE_OPT: pause_opt_d = obj_wdata_i[15:0];
        IDX_MODE_SEL: begin
          // (RQ4) Torque mode refused.
          if (obj_wdata_i[7:0] == MODE_PT || obj_wdata_i[7:0] > MODE_MAX) begin
            err_d = 1'b1;
          end else begin
            mode_d = obj_wdata_i[7:0];
          end
        end
        IDX_POS_THR: pos_thr_d = obj_wdata_i;
        IDX_POS_WIN: pos_win_d = obj_wdata_i[15:0];
        IDX_SPD_THR: spd_thr_d = obj_wdata_i[15:0];
        IDX_SPD_WIN: spd_win_d = obj_wdata_i[15:0];
        IDX_ORIGIN_OFS: origin_d = obj_wdata_i;
        IDX_HOME_METHOD: begin
          // (RQ14) Method range check.
          if ($signed(obj_wdata_i[7:0]) >= $signed(METHOD_MIN) && $signed(obj_wdata_i[7:0]) <= $signed(METHOD_MAX)) begin
            method_d = obj_wdata_i[7:0];
          end else begin
            err_d = 1'b1;
          end
        end
        IDX_HOME_SPEED: begin
          // (RQ15) Search speeds with slow floor.
          if (obj_sub_i == SUB_FAST) begin
            fast_d = obj_wdata_i;
          end else if (obj_sub_i == SUB_SLOW) begin
            slow_d = (obj_wdata_i < SLOW_MIN) ? SLOW_MIN : obj_wdata_i;
          end else begin
            err_d = 1'b1;
          end
        end
        IDX_HOME_ACCEL: accel_d = obj_wdata_i;
        IDX_POS_CALC: calc_d = obj_wdata_i[0];
        IDX_TARGET_VEL: tgt_vel_d = obj_wdata_i;
        default: err_d = 1'b1;
      endcase
    end else if (obj_rd_i) begin
      rdata_d = 32'h0;
      unique case (obj_index_i)
        IDX_ERROR_CODE: rdata_d = {16'h0, err_code_q};
        IDX_CONTROL: rdata_d = {16'h0, cw_q};
        IDX_STATUS: rdata_d = {16'h0, sw_q};
        IDX_PAUSE_OPT: rdata_d = {16'h0, pause_opt_q};
        IDX_MODE_SEL, IDX_MODE_DISP: rdata_d = {{24{mode_q[7]}}, mode_q};
        IDX_POS_DEMAND: rdata_d = pos_demand_i;
        IDX_POS_FB: rdata_d = pfb_q;
        IDX_POS_THR: rdata_d = pos_thr_q;
        IDX_POS_WIN: rdata_d = {16'h0, pos_win_q};
        IDX_SPD_FB: rdata_d = speed_feedback_i;
        IDX_SPD_THR: rdata_d = {16'h0, spd_thr_q};
        IDX_SPD_WIN: rdata_d = {16'h0, spd_win_q};
        IDX_TORQUE: rdata_d = {{16{torque_i[15]}}, torque_i};
        IDX_ORIGIN_OFS: rdata_d = origin_q;
        IDX_HOME_METHOD: rdata_d = {{24{method_q[7]}}, method_q};
        IDX_HOME_SPEED: begin
          if (obj_sub_i == SUB_FAST) begin
            rdata_d = fast_q;
          end else if (obj_sub_i == SUB_SLOW) begin
            rdata_d = slow_q;
          end else begin
            err_d = 1'b1;
          end
        end
        IDX_HOME_ACCEL: rdata_d = accel_q;
        IDX_POS_CALC: rdata_d = {31'h0, calc_q};
        IDX_FOLLOW_ERR: rdata_d = follow_err_i;
        IDX_TARGET_VEL: rdata_d = tgt_vel_q;
        default: err_d = 1'b1;
      endcase
    end
  end

  // Millisecond tick and the two reach detectors. Counting whole ticks means a
  // window can be up to one tick short, the price of sharing a single divider.
  always_comb begin
    tick_d = (ms_cnt_q == 32'(CYC_PER_MS_P - 1));
    ms_cnt_d = tick_d ? 32'h0 : (ms_cnt_q + 32'h1);
    spd_cnt_d = spd_cnt_q;
    pos_cnt_d = pos_cnt_q;
    // (RQ2) Only enabled velocity modes qualify.
    if (!(en_q && vel_mode && spd_in_band)) begin
      spd_cnt_d = 16'h0;
    end else if (tick_q && spd_cnt_q < spd_win_q) begin
      spd_cnt_d = spd_cnt_q + 16'h1;
    end
    // (RQ1) Band held for the window.
    spd_ok_d = en_q && vel_mode && spd_in_band && (spd_cnt_q >= spd_win_q);
    // (RQ13) Position held for the window.
    if (!pos_in_band) begin
      pos_cnt_d = 16'h0;
    end else if (tick_q && pos_cnt_q < pos_win_q) begin
      pos_cnt_d = pos_cnt_q + 16'h1;
    end
    pos_ok_d = pos_in_band && (pos_cnt_q >= pos_win_q);
  end

  // Homing sequencer, origin handling and drive control.
  always_comb begin
    home_d = home_q;
    to_cnt_d = to_cnt_q;
    ofs_d = ofs_q;
    found_d = found_q;
    hok_d = hok_q;
    herr_d = herr_q;
    err_code_d = err_code_q;
    // (RQ6) Operation enable.
    en_d = enable_ok;
    // (RQ9) Pause follows bit eight.
    pause_d = cw_q[CW_PAUSE_BIT];
    if (home_start) begin
      home_d = SVRH_SEEK;
      to_cnt_d = 32'h0;
      // (RQ19) Fresh run clears flags.
      found_d = 1'b0;
      hok_d = 1'b0;
      herr_d = 1'b0;
      err_code_d = 16'h0;
    end else begin
      unique case (home_q)
        SVRH_IDLE: begin
        end
        SVRH_SEEK: begin
          if (tick_q && !pause_q) begin
            to_cnt_d = to_cnt_q + 32'h1;
          end
          // (RQ12) Home signal met.
          if (home_rise) begin
            found_d = 1'b1;
          end
          // (RQ8) Bit four dropped ends homing.
          if (!cw_q[CW_HOMING_BIT] || !en_q) begin
            home_d = SVRH_IDLE;
          end else if (dev_big || to_cnt_q >= HOME_TIMEOUT_MS) begin
            // (RQ11) Timeout or deviation error.
            home_d = SVRH_FAIL;
            herr_d = 1'b1;
            err_code_d = HOME_ERR_CODE;
          end else if (homing_stop_i) begin
            home_d = SVRH_DONE;
            // (RQ5) Origin at stop point.
            // (RQ16) Rest point is the reference.
            // (RQ18) Absolute or relative offset.
            ofs_d = calc_q ? (ofs_q + origin_q) : (origin_q - raw_position_i);
          end
        end
        SVRH_DONE: begin
          // (RQ10) Success after target reached.
          if (pos_ok_q && mode_q == MODE_HM) begin
            hok_d = 1'b1;
          end
          if (!cw_q[CW_HOMING_BIT]) begin
            home_d = SVRH_IDLE;
          end
        end
        SVRH_FAIL: begin
          if (!cw_q[CW_HOMING_BIT]) begin
            home_d = SVRH_IDLE;
          end
        end
      endcase
    end
    pfb_d = raw_position_i + ofs_q;
    // (RQ3) Status bit and output from one source in velocity modes; bit ten shows position reached otherwise.
    sw_d = 16'h0;
    sw_d[SW_REACH_BIT] = vel_mode ? spd_ok_d : pos_ok_d;
    sw_d[SW_HOME_OK_BIT] = hok_d;
    sw_d[SW_HOME_ERR_BIT] = herr_d;
    sw_d[SW_HOME_FOUND_BIT] = found_d;
  end

  // Registers; all control state returns to its reset value synchronously.
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      cw_q <= 16'h0;
      err_code_q <= 16'h0;
      pause_opt_q <= 16'h0;
      mode_q <= 8'h0;
      method_q <= RST_METHOD;
      pos_thr_q <= RST_POS_THR;
      pos_win_q <= RST_POS_WIN;
      spd_thr_q <= RST_SPD_THR;
      spd_win_q <= RST_SPD_WIN;
      origin_q <= 32'h0;
      tgt_vel_q <= 32'h0;
      fast_q <= RST_HOME_SPEED;
      slow_q <= RST_HOME_SPEED;
      accel_q <= RST_HOME_ACCEL;
      calc_q <= 1'b0;
      rdata_q <= 32'h0;
      ack_q <= 1'b0;
      err_q <= 1'b0;
      ms_cnt_q <= 32'h0;
      tick_q <= 1'b0;
      spd_cnt_q <= 16'h0;
      pos_cnt_q <= 16'h0;
      spd_ok_q <= 1'b0;
      pos_ok_q <= 1'b0;
      home_q <= SVRH_IDLE;
      to_cnt_q <= 32'h0;
      ofs_q <= 32'h0;
      pfb_q <= 32'h0;
      found_q <= 1'b0;
      hok_q <= 1'b0;
      herr_q <= 1'b0;
      bit4_prev_q <= 1'b0;
      en_q <= 1'b0;
      pause_q <= 1'b0;
      sw_q <= 16'h0;
      home_meta_q <= 1'b0;
      home_sync_q <= 1'b0;
      home_prev_q <= 1'b0;
    end else begin
      cw_q <= cw_d;
      err_code_q <= err_code_d;
      pause_opt_q <= pause_opt_d;
      mode_q <= mode_d;
      method_q <= method_d;
      pos_thr_q <= pos_thr_d;
      pos_win_q <= pos_win_d;
      spd_thr_q <= spd_thr_d;
      spd_win_q <= spd_win_d;
      origin_q <= origin_d;
      tgt_vel_q <= tgt_vel_d;
      fast_q <= fast_d;
      slow_q <= slow_d;
      accel_q <= accel_d;
      calc_q <= calc_d;
      rdata_q <= rdata_d;
      ack_q <= ack_d;
      err_q <= err_d;
      ms_cnt_q <= ms_cnt_d;
      tick_q <= tick_d;
      spd_cnt_q <= spd_cnt_d;
      pos_cnt_q <= pos_cnt_d;
      spd_ok_q <= spd_ok_d;
      pos_ok_q <= pos_ok_d;
      home_q <= home_d;
      to_cnt_q <= to_cnt_d;
      ofs_q <= ofs_d;
      pfb_q <= pfb_d;
      found_q <= found_d;
      hok_q <= hok_d;
      herr_q <= herr_d;
      bit4_prev_q <= cw_q[CW_HOMING_BIT];
      en_q <= en_d;
      pause_q <= pause_d;
      sw_q <= sw_d;
      home_meta_q <= home_sw_i;
      home_sync_q <= home_meta_q;
      home_prev_q <= home_sync_q;
    end
  end

  // Outputs are straight register copies, except homing_run_o, which is decoded from the homing state.
  assign obj_rdata_o = rdata_q;
  assign obj_ack_o = ack_q;
  assign obj_err_o = err_q;
  assign drive_enable_o = en_q;
  assign active_mode_o = mode_q;
  assign pause_o = pause_q;
  assign pause_option_o = pause_opt_q;
  assign speed_reached_do_o = spd_ok_q;
  assign status_word_o = sw_q;
  assign position_feedback_o = pfb_q;
  assign homing_run_o = (home_q == SVRH_SEEK);
  assign homing_method_o = method_q;
  assign homing_fast_o = fast_q;
  assign homing_slow_o = slow_q;
  assign homing_accel_o = accel_q;

  // Named steps of a homing run.
  sequence s_home_start;
    home_start;
  endsequence
  sequence s_home_cleared;
    homing_run_o && !status_word_o[SW_HOME_OK_BIT] && !status_word_o[SW_HOME_ERR_BIT];
  endsequence

  a_speed_do_match: assert property (@(posedge sys_clk_i) disable iff (rst_i) // (RQ3)
    vel_mode |-> (status_word_o[SW_REACH_BIT] == speed_reached_do_o))
    else $error("speed output and status bit differ");
  a_speed_band_drop: assert property (@(posedge sys_clk_i) disable iff (rst_i) // (RQ1)
    !spd_in_band |=> !speed_reached_do_o)
    else $error("speed reached outside the band");
  a_speed_mode_gate: assert property (@(posedge sys_clk_i) disable iff (rst_i) // (RQ2)
    !(en_q && vel_mode) |=> !speed_reached_do_o)
    else $error("speed reached outside velocity operation");
  a_torque_refused: assert property (@(posedge sys_clk_i) disable iff (rst_i) // (RQ4)
    (obj_wr_i && obj_index_i == IDX_MODE_SEL && obj_wdata_i[7:0] == MODE_PT)
      |=> $stable(active_mode_o) && obj_err_o)
    else $error("torque mode was accepted");
  a_enable_bits: assert property (@(posedge sys_clk_i) disable iff (rst_i) // (RQ6)
    !(&cw_q[3:0]) |=> !drive_enable_o ##1 !homing_run_o)
    else $error("operation without all start bits");
  a_home_start_clr: assert property (@(posedge sys_clk_i) disable iff (rst_i) // (RQ19)
    s_home_start |=> s_home_cleared)
    else $error("homing start did not clear flags");
  a_home_end_edge: assert property (@(posedge sys_clk_i) disable iff (rst_i) // (RQ8)
    (homing_run_o && !cw_q[CW_HOMING_BIT]) |=> !homing_run_o)
    else $error("homing continued after bit four fell");
  a_pause_follow: assert property (@(posedge sys_clk_i) disable iff (rst_i) // (RQ9)
    cw_q[CW_PAUSE_BIT] |=> pause_o)
    else $error("pause not applied");
  a_home_found: assert property (@(posedge sys_clk_i) disable iff (rst_i) // (RQ12)
    (homing_run_o && home_rise && !home_start) |=> ##1 status_word_o[SW_HOME_FOUND_BIT])
    else $error("home signal not reported");
  a_origin_abs: assert property (@(posedge sys_clk_i) disable iff (rst_i) // (RQ18)
    (home_q == SVRH_SEEK && home_d == SVRH_DONE && !calc_q) |=> (ofs_q == $past(origin_q) - $past(raw_position_i)))
    else $error("absolute origin not loaded");
  a_slow_floor: assert property (@(posedge sys_clk_i) disable iff (rst_i) // (RQ15)
    homing_slow_o >= SLOW_MIN)
    else $error("slow search speed below floor");
  a_method_range: assert property (@(posedge sys_clk_i) disable iff (rst_i) // (RQ14)
    $signed(homing_method_o) >= $signed(METHOD_MIN) && $signed(homing_method_o) <= $signed(METHOD_MAX))
    else $error("homing method out of range");
endmodule

// ---- svrh_pkg.sv ----
/*
 Shared constants of the servo velocity-reach and homing block: object
 indices, control and status word bit positions, reset values, mode codes,
 homing states and timing figures. Assumes a 200 MHz system clock.
*/
package svrh_pkg;
  // Object dictionary indices and sub-indices.
  localparam logic [15:0] IDX_ERROR_CODE = 16'h603f;
  localparam logic [15:0] IDX_CONTROL = 16'h6040;
  localparam logic [15:0] IDX_STATUS = 16'h6041;
  localparam logic [15:0] IDX_PAUSE_OPT = 16'h605d;
  localparam logic [15:0] IDX_MODE_SEL = 16'h6060;
  localparam logic [15:0] IDX_MODE_DISP = 16'h6061;
  localparam logic [15:0] IDX_POS_DEMAND = 16'h6062;
  localparam logic [15:0] IDX_POS_FB = 16'h6064;
  localparam logic [15:0] IDX_POS_THR = 16'h6067;
  localparam logic [15:0] IDX_POS_WIN = 16'h6068;
  localparam logic [15:0] IDX_SPD_FB = 16'h606c;
  localparam logic [15:0] IDX_SPD_THR = 16'h606d;
  localparam logic [15:0] IDX_SPD_WIN = 16'h606e;
  localparam logic [15:0] IDX_TORQUE = 16'h6077;
  localparam logic [15:0] IDX_ORIGIN_OFS = 16'h607c;
  localparam logic [15:0] IDX_HOME_METHOD = 16'h6098;
  localparam logic [15:0] IDX_HOME_SPEED = 16'h6099;
  localparam logic [15:0] IDX_HOME_ACCEL = 16'h609a;
  localparam logic [15:0] IDX_POS_CALC = 16'h60e6;
  localparam logic [15:0] IDX_FOLLOW_ERR = 16'h60f4;
  localparam logic [15:0] IDX_TARGET_VEL = 16'h60ff;
  localparam logic [7:0] SUB_FAST = 8'h01;
  localparam logic [7:0] SUB_SLOW = 8'h02;
  // Control and status word bit positions.
  localparam int CW_HOMING_BIT = 4;
  localparam int CW_PAUSE_BIT = 8;
  localparam int SW_REACH_BIT = 10;
  localparam int SW_HOME_OK_BIT = 12;
  localparam int SW_HOME_ERR_BIT = 13;
  localparam int SW_HOME_FOUND_BIT = 15;
  // Operation mode codes.
  localparam logic [7:0] MODE_PV = 8'h03;
  localparam logic [7:0] MODE_PT = 8'h04;
  localparam logic [7:0] MODE_HM = 8'h06;
  localparam logic [7:0] MODE_CSV = 8'h09;
  localparam logic [7:0] MODE_MAX = 8'h0a;
  // Homing method range and speed floor.
  localparam logic [7:0] METHOD_MIN = 8'h01;
  localparam logic [7:0] METHOD_MAX = 8'h23;
  localparam logic [31:0] SLOW_MIN = 32'h0000000a;
  // Reset values and the homing error code.
  localparam logic [31:0] RST_POS_THR = 32'h000002de;
  localparam logic [15:0] RST_POS_WIN = 16'h000a;
  localparam logic [15:0] RST_SPD_THR = 16'h000a;
  localparam logic [15:0] RST_SPD_WIN = 16'h000a;
  localparam logic [7:0] RST_METHOD = 8'h01;
  localparam logic [31:0] RST_HOME_SPEED = 32'h00000064;
  localparam logic [31:0] RST_HOME_ACCEL = 32'h00000064;
  localparam logic [15:0] HOME_ERR_CODE = 16'h0001;
  // Timing: clock rate and the millisecond tick derived from it.
  localparam int CLK_HZ = 200_000_000;
  localparam int TICK_MS = 1;
  localparam int CYC_PER_MS = CLK_HZ / 1000 * TICK_MS;
  // Homing sequencer states.
  typedef enum logic [1:0] {
    SVRH_IDLE = 2'b00,
    SVRH_SEEK = 2'b01,
    SVRH_DONE = 2'b10,
    SVRH_FAIL = 2'b11
  } svrh_home_t;
endpackage

// ---- svrh_ctl_model.sv ----
/*
 Upper controller model: issues single-cycle object strobes to the core.
 Assumes the core acknowledges exactly one cycle after each strobe.
*/
`timescale 1ns/10ps
module svrh_ctl_model (
  // Clock.
  input wire logic sys_clk_i,
  // Object strobes toward the core.
  output logic obj_wr_o,
  output logic obj_rd_o,
  output logic [15:0] obj_index_o,
  output logic [7:0] obj_sub_o,
  output logic [31:0] obj_wdata_o,
  // Answer from the core.
  input wire logic [31:0] obj_rdata_i,
  input wire logic obj_ack_i,
  input wire logic obj_err_i
);
  // Idle bus at time zero.
  initial begin
    obj_wr_o = 1'h0;
    obj_rd_o = 1'h0;
    obj_index_o = 16'h0;
    obj_sub_o = 8'h0;
    obj_wdata_o = 32'h0;
  end
  // object writes and reads sent.
  // Index and data are inverted once released, so a stale value never passes for a live one.
  task automatic xfer(input logic w, input logic [15:0] i, input logic [7:0] s, input logic [31:0] d,
                      output logic [31:0] q, output logic [1:0] a);
    @(posedge sys_clk_i);
    obj_wr_o <= w;
    obj_rd_o <= !w;
    obj_index_o <= i;
    obj_sub_o <= s;
    obj_wdata_o <= d;
    @(posedge sys_clk_i);
    obj_wr_o <= 1'h0;
    obj_rd_o <= 1'h0;
    obj_index_o <= ~i;
    obj_wdata_o <= ~d;
    #1;
    q = obj_rdata_i;
    a = {obj_ack_i, obj_err_i};
  endtask
endmodule

// ---- tb_svrh_core.sv ----
/*
 Self-checking bench of the velocity-reach and homing core.
 Assumes short ms tick (10 cycles) and a 5 ms homing timeout.
*/
`timescale 1ns/10ps
module tb_svrh_core;
  import svrh_pkg::*;
  logic sys_clk_i = 1'h0;
  logic rst_i = 1'h1;
  logic home_sw = 1'h0;
  logic hstop = 1'h0;
  logic [31:0] rpm = 32'h0;
  logic [31:0] raw = 32'h0;
  logic [31:0] ferr = 32'h0;
  logic [31:0] q;
  logic [1:0] ae;
  logic wr, rd, ack, err, den, pau, sdo, hrun;
  logic [15:0] idx, sw;
  logic [7:0] sub;
  logic [31:0] wd, rdat, pfb;
  int n_errors = 0;
  int n_checks = 0;
  always #2.5 sys_clk_i = ~sys_clk_i;
  svrh_ctl_model i_ctl (.sys_clk_i(sys_clk_i), .obj_wr_o(wr), .obj_rd_o(rd), .obj_index_o(idx),
    .obj_sub_o(sub), .obj_wdata_o(wd), .obj_rdata_i(rdat), .obj_ack_i(ack), .obj_err_i(err));
  svrh_core #(.CYC_PER_MS_P(10), .HOME_TIMEOUT_MS(32'h5)) i_dut (.sys_clk_i(sys_clk_i), .rst_i(rst_i),
    .obj_wr_i(wr), .obj_rd_i(rd), .obj_index_i(idx), .obj_sub_i(sub), .obj_wdata_i(wd),
    .obj_rdata_o(rdat), .obj_ack_o(ack), .obj_err_o(err), .motor_rpm_i(rpm), .raw_position_i(raw),
    .pos_demand_i(32'h0), .speed_feedback_i(32'h0), .torque_i(16'h0), .follow_err_i(ferr),
    .homing_stop_i(hstop), .home_sw_i(home_sw), .drive_enable_o(den), .active_mode_o(),
    .pause_o(pau), .pause_option_o(), .speed_reached_do_o(sdo), .status_word_o(sw),
    .position_feedback_o(pfb), .homing_run_o(hrun), .homing_method_o(), .homing_fast_o(),
    .homing_slow_o(), .homing_accel_o());
  // Compare one value against its expectation.
  task automatic chk(input string nm, input logic [31:0] s, input logic [31:0] e);
    n_checks++;
    if (s !== e) begin
      n_errors++;
      $display("Error %s expected %h seen %h", nm, e, s);
    end
  endtask
  task automatic wr_obj(input logic [15:0] i, input logic [7:0] s, input logic [31:0] d, input logic [1:0] ex);
    i_ctl.xfer(1'h1, i, s, d, q, ae);
    chk("write answer", {30'h0, ae}, {30'h0, ex});
  endtask
  task automatic rd_obj(input logic [15:0] i, input logic [7:0] s, input logic [31:0] e);
    i_ctl.xfer(1'h0, i, s, 32'h0, q, ae);
    chk("read answer", {30'h0, ae}, 32'h2);
    chk("read data", q, e);
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge sys_clk_i);
    #1;
  endtask
  // Single place where the run ends.
  task automatic complete_run();
    if (n_errors == 0 && n_checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  // A hung wait must not stall the run forever.
  initial begin
    repeat (20000) @(posedge sys_clk_i);
    n_errors++;
    complete_run();
  end
  initial begin
    repeat (16) @(posedge sys_clk_i);
    rst_i <= 1'h0;
    rd_obj(IDX_HOME_METHOD, 8'h0, 32'h1);
    rd_obj(IDX_HOME_SPEED, SUB_FAST, 32'h64);
    rd_obj(IDX_HOME_SPEED, SUB_SLOW, 32'h64);
    rd_obj(IDX_POS_THR, 8'h0, 32'h2de);
    wr_obj(IDX_HOME_SPEED, SUB_SLOW, 32'h5, 2'h2);
    rd_obj(IDX_HOME_SPEED, SUB_SLOW, 32'ha);
    wr_obj(IDX_HOME_METHOD, 8'h0, 32'h24, 2'h3);
    wr_obj(IDX_MODE_SEL, 8'h0, 32'h4, 2'h3);
    rd_obj(IDX_MODE_DISP, 8'h0, 32'h0);
    wr_obj(IDX_STATUS, 8'h0, 32'h1, 2'h3);
    wr_obj(16'h6fff, 8'h0, 32'h1, 2'h3);
    wr_obj(IDX_MODE_SEL, 8'h0, 32'h3, 2'h2);
    wr_obj(IDX_TARGET_VEL, 8'h0, 32'h3e8, 2'h2);
    wr_obj(IDX_CONTROL, 8'h0, 32'h7, 2'h2);
    cyc(2);
    chk("enable", den, 1'h0);
    wr_obj(IDX_CONTROL, 8'h0, 32'h10f, 2'h2);
    cyc(2);
    chk("pause", pau, 1'h1);
    wr_obj(IDX_CONTROL, 8'h0, 32'hf, 2'h2);
    cyc(2);
    chk("enable", den, 1'h1);
    rpm <= 32'h3ed;
    repeat (200) if (!sw[SW_REACH_BIT]) cyc(1);
    chk("reach and output", {sw[SW_REACH_BIT], sdo}, 2'h3);
    rpm <= 32'h0;
    cyc(3);
    chk("reach lost", {sw[SW_REACH_BIT], sdo}, 2'h0);
    rpm <= 32'h3e8;
    wr_obj(IDX_MODE_SEL, 8'h0, 32'h6, 2'h2);
    cyc(3);
    chk("reach output", sdo, 1'h0);
    wr_obj(IDX_ORIGIN_OFS, 8'h0, 32'h100, 2'h2);
    wr_obj(IDX_POS_CALC, 8'h0, 32'h0, 2'h2);
    wr_obj(IDX_CONTROL, 8'h0, 32'h1f, 2'h2);
    cyc(3);
    chk("homing run", hrun, 1'h1);
    home_sw <= 1'h1;
    cyc(6);
    chk("home found", sw[SW_HOME_FOUND_BIT], 1'h1);
    raw <= 32'h55;
    hstop <= 1'h1;
    cyc(1);
    hstop <= 1'h0;
    cyc(3);
    chk("origin", pfb, 32'h100);
    raw <= 32'h60;
    cyc(2);
    chk("feedback", pfb, 32'h10b);
    repeat (200) if (!sw[SW_HOME_OK_BIT]) cyc(1);
    chk("homing ok", sw[SW_HOME_OK_BIT], 1'h1);
    home_sw <= 1'h0;
    wr_obj(IDX_CONTROL, 8'h0, 32'hf, 2'h2);
    cyc(3);
    chk("homing end", hrun, 1'h0);
    wr_obj(IDX_CONTROL, 8'h0, 32'h1f, 2'h2);
    cyc(3);
    chk("flags cleared", {sw[15], sw[13], sw[12]}, 3'h0);
    ferr <= 32'h200000;
    cyc(4);
    chk("homing error", sw[SW_HOME_ERR_BIT], 1'h1);
    rd_obj(IDX_ERROR_CODE, 8'h0, {16'h0, HOME_ERR_CODE});
    complete_run();
  end
endmodule
